//--- verilog/host_port_pkg.sv
// Purpose: Shared constants and types for the parallel host port.
// Assumes: Byte-wide register space, 8-bit address including the lane bit.
// Notes: Address map of flag, mask and summary registers is local to this port.
package host_port_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;
  localparam int PIN_W = 32;
  localparam int FIFO_W = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int NUM_EVT_REGS = 6;
  localparam int EVT_W = 8;
  localparam int ALL_EVT_W = 48;

  localparam logic [7:0] FIFO_ADDR = 8'h00;
  localparam logic [7:0] MASK_BASE = 8'h60;
  localparam logic [7:0] FLAG_BASE = 8'h68;
  localparam logic [7:0] SUMMARY_ADDR = 8'h6e;
  localparam logic [7:0] MASK_RESET = 8'hff;
  localparam logic [31:0] PIN_IDLE = 32'h7c000000;

  localparam logic [5:0] RX_LEN_MIN = 6'h02;
  localparam logic [5:0] RX_LEN_RESET = 6'h20;

  localparam logic [1:0] KIND_FIFO = 2'h0;
  localparam logic [1:0] KIND_STAT = 2'h1;
  localparam logic [1:0] KIND_MASK = 2'h2;
  localparam logic [1:0] KIND_EXT = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FIRST = 2'b01,
    ST_SECOND = 2'b11,
    ST_HOLD = 2'b10
  } port_state_e;
endpackage : host_port_pkg

//--- verilog/byte_fifo.sv
// Purpose: Synchronous byte queue with valid/ready on both sides.
// Assumes: One push and one pop per clock at most.
// Notes: Full and empty come from the occupancy count.
`timescale 1ns/10ps
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [WIDTH-1:0] i_w_data,
  input wire logic i_w_valid,
  output logic o_w_ready,
  output logic [WIDTH-1:0] o_r_data,
  output logic o_r_valid,
  input wire logic i_r_ready,
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } fifo_s;
  fifo_s s_q, s_d;
  logic push, pop;

  assign o_w_ready = s_q.cnt != PW'(0) + (PW+1)'(DEPTH) ? 1'b1 : 1'b0;
  assign o_r_valid = s_q.cnt != '0;
  assign o_r_data = s_q.mem[s_q.rp];
  assign o_count = s_q.cnt;
  assign push = i_w_valid && o_w_ready;
  assign pop = i_r_ready && o_r_valid;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = i_w_data;
      s_d.wp = s_q.wp + PW'(1);
    end
    if (pop) begin
      s_d.rp = s_q.rp + PW'(1);
    end
    s_d.cnt = s_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  a_fifo_bound: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    s_q.cnt <= (PW+1)'(DEPTH)) else $error("fifo count above depth");
  a_full_refuse: assert property (@(posedge i_ref_clk) disable iff (i_reset)
    (!o_w_ready && !pop) |=> $stable(s_q.cnt)) else $error("push taken while full");
endmodule : byte_fifo
`default_nettype wire

//--- verilog/event_flag_reg.sv
// Purpose: One clear-on-read event flag register with mask and hold-off.
// Assumes: Events are one-cycle pulses; clear carries the bits that were read.
// Notes: Events during hold-off are parked and merged when it ends.
`timescale 1ns/10ps
`default_nettype none
module event_flag_reg (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [host_port_pkg::EVT_W-1:0] i_events,
  input wire logic [host_port_pkg::EVT_W-1:0] i_mask,
  input wire logic i_show_masked,
  input wire logic i_freeze,
  input wire logic [host_port_pkg::EVT_W-1:0] i_clear,
  output logic [host_port_pkg::EVT_W-1:0] o_visible,
  output logic o_active
);
  import host_port_pkg::*;
  typedef struct packed {
    logic [EVT_W-1:0] flags;
    logic [EVT_W-1:0] pend;
  } evt_s;
  evt_s s_q, s_d;
  logic [EVT_W-1:0] set;

  // Masked events are dropped unless the visible mode keeps them
  assign set = i_events & (~i_mask | {EVT_W{i_show_masked}}); // [RULE12] [RULE16]
  assign o_visible = i_show_masked ? s_q.flags : (s_q.flags & ~i_mask); // [RULE12] [RULE16]
  assign o_active = |(s_q.flags & ~i_mask);

  always_comb begin
    s_d = s_q;
    if (i_freeze) begin
      s_d.pend = s_q.pend | set; // [RULE15]
    end else begin
      // Set wins over the clear of the same bit
      s_d.flags = (s_q.flags & ~i_clear) | s_q.pend | set; // [RULE11] [RULE17]
      s_d.pend = '0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  a_freeze_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [RULE15]
    i_freeze |=> $stable(s_q.flags)) else $error("flags changed during read");
  a_set_wins: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [RULE11]
    (!i_freeze && set != '0) |=> ((s_q.flags & $past(set)) == $past(set)))
    else $error("event lost against clear");
  a_mask_hidden: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [RULE12]
    !i_show_masked |-> ((o_visible & i_mask) == '0)) else $error("masked flag visible");
endmodule : event_flag_reg
`default_nettype wire

//--- verilog/host_bus_port.sv
// Purpose: Parallel host port with byte steering, HDLC queues and event flags.
// Assumes: Pins are asynchronous and pass two flops; strobes far slower than clock.
// Notes: Registers outside flags, masks, summary and queues go to the ext port.
// Behaviour
// RULE1: Two strobe styles, 8 or 16 bit bus
// RULE2: Strobe style lanes follow upper select, A0
// RULE3: Data-strobe lanes follow lower select, A0
// RULE4: Latch strobe and style pin choose structure
// RULE5: Word register lanes swap with bus style
// RULE6: Mixed byte and word queue access allowed
// RULE7: One 32-byte half per direction faces processor
// RULE8: Word queue access only on 16-bit bus
// RULE9: Receive accessible length 2 to 32 bytes
// RULE10: Single interrupt pin, driver type configurable
// RULE11: Event flag registers clear on read
// RULE12: Masked flags hidden and raise no interrupt
// RULE13: Summary points to unmasked pending flag registers
// RULE14: Interrupt drops when summary returns to zero
// RULE15: Flag updates held off during their read
// RULE16: Visible mode shows masked flags, no interrupt
// RULE17: Visible mode read clears every active flag
// RULE18: Processor reads summary first, then flags
// RULE19: Polling reads each flag register separately
// RULE20: 8-bit bus uses low lane only
`timescale 1ns/10ps
`default_nettype none
module host_bus_port (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_bus_style_select,
  input wire logic i_bus_width_select,
  input wire logic i_ale,
  input wire logic i_cs_n,
  input wire logic i_rd_rw,
  input wire logic i_wr_ds_n,
  input wire logic i_upper_lane_select_n,
  input wire logic i_lower_lane_select_n,
  input wire logic [host_port_pkg::ADDR_W-1:0] i_addr,
  input wire logic [host_port_pkg::DATA_W-1:0] i_data,
  output logic [host_port_pkg::DATA_W-1:0] o_data,
  output logic o_data_oe,
  output logic o_irq_out_n,
  output logic o_irq_out_oe,
  input wire logic i_irq_output_config,
  input wire logic i_show_masked_events,
  input wire logic [host_port_pkg::ALL_EVT_W-1:0] i_events,
  output logic o_reg_rd,
  output logic o_reg_wr,
  output logic [host_port_pkg::ADDR_W-1:0] o_reg_addr,
  output logic [1:0] o_reg_be,
  output logic [host_port_pkg::DATA_W-1:0] o_reg_wdata,
  input wire logic [host_port_pkg::DATA_W-1:0] i_reg_rdata,
  input wire logic [host_port_pkg::FIFO_W-1:0] i_rx_data,
  input wire logic i_rx_valid,
  output logic o_rx_ready,
  input wire logic [5:0] i_rx_queue_length,
  output logic o_rx_block_ready,
  output logic [host_port_pkg::FIFO_W-1:0] o_tx_data,
  output logic o_tx_valid,
  input wire logic i_tx_ready
);
  import host_port_pkg::*;

  typedef struct packed {
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    logic ale_prev;
    logic muxed;
    logic [ADDR_W-1:0] ale_addr;
    port_state_e st;
    logic [ADDR_W-1:0] addr;
    logic rd;
    logic [1:0] be;
    logic wide;
    logic swap;
    logic [DATA_W-1:0] wd;
    logic [DATA_W-1:0] rdl;
    logic [DATA_W-1:0] dout;
    logic doe;
    logic reg_rd;
    logic reg_wr;
    logic [ALL_EVT_W-1:0] mask;
    logic [NUM_EVT_REGS-1:0] summary;
    logic irq_n;
    logic irq_oe;
    logic blk_rdy;
  } port_s;

  port_s s_q, s_d;

  logic s_ale, s_cs_n, s_rd_rw, s_wr_ds_n, s_upper_n, s_lower_n, s_style, s_width;
  logic [ADDR_W-1:0] s_addr;
  logic [DATA_W-1:0] s_data;
  logic style_ds, acc, is_read, sel_n, a0;
  logic [1:0] be_c;
  logic [ADDR_W-1:0] cur_addr;
  logic [EVT_W-1:0] lane0_in, lane1_in;
  logic [1:0] kind_c, kind_q;
  logic [2:0] idx0, idx1;
  logic [63:0] stat_bytes;
  logic [ALL_EVT_W-1:0] visible, clr;
  logic [NUM_EVT_REGS-1:0] active;
  logic stat_busy, release_c, freeze, cl;
  logic rx_pop, tx_push;
  logic [FIFO_W-1:0] tx_byte, rx_head;
  logic rx_valid_h, tx_ready_h;
  logic [$clog2(FIFO_DEPTH):0] rx_count;
  logic [5:0] rx_len;

  function automatic logic [1:0] kind_of(input logic [ADDR_W-1:0] a);
    logic [1:0] k;
    k = KIND_EXT;
    if (a[7:1] == FIFO_ADDR[7:1]) begin
      k = KIND_FIFO;
    end else if (a[7:3] == FLAG_BASE[7:3]) begin
      k = KIND_STAT;
    end else if (a[7:3] == MASK_BASE[7:3] && a[2:1] != 2'b11) begin
      k = KIND_MASK;
    end
    return k;
  endfunction : kind_of

  assign {s_ale, s_cs_n, s_rd_rw, s_wr_ds_n, s_upper_n, s_lower_n, s_style, s_width,
          s_addr, s_data} = s_q.sync2;

  // Multiplexed bus only in strobe style
  assign style_ds = s_style && !s_q.muxed; // [RULE4]
  assign acc = !s_cs_n && (style_ds ? !s_wr_ds_n : (!s_rd_rw || !s_wr_ds_n)); // [RULE1]
  assign is_read = style_ds ? s_rd_rw : !s_rd_rw;
  assign cur_addr = s_q.muxed ? s_q.ale_addr : s_addr; // [RULE4]
  assign a0 = cur_addr[0];
  assign sel_n = style_ds ? s_lower_n : s_upper_n; // [RULE2] [RULE3]

  always_comb begin
    if (!s_width) begin
      be_c = a0 ? 2'b10 : 2'b01; // [RULE20]
    end else begin
      case ({sel_n, a0}) // [RULE2] [RULE3]
        2'b00: be_c = 2'b11;
        2'b01: be_c = 2'b10;
        2'b10: be_c = 2'b01;
        default: be_c = 2'b00;
      endcase
    end
  end

  // Lane 0 is the even register; 16-bit data-strobe style carries it on the high pins
  assign lane0_in = (s_width && style_ds) ? s_data[15:8] : s_data[7:0]; // [RULE5]
  assign lane1_in = (s_width && !style_ds) ? s_data[15:8] : s_data[7:0]; // [RULE5]

  assign kind_c = kind_of(cur_addr);
  assign kind_q = kind_of(s_q.addr);
  assign idx0 = {s_q.addr[2:1], 1'b0};
  assign idx1 = {s_q.addr[2:1], 1'b1};
  assign stat_bytes = {8'h00, 2'b00, s_q.summary, visible};
  assign cl = (s_q.st == ST_SECOND) || (s_q.be == 2'b10);

  assign stat_busy = (s_q.st != ST_IDLE) && s_q.rd && (kind_q == KIND_STAT);
  assign release_c = (s_q.st == ST_HOLD) && !acc;
  assign freeze = stat_busy && !release_c; // [RULE15]

  always_comb begin
    clr = '0;
    if (stat_busy && release_c) begin
      if (s_q.be[0] && idx0 < 3'(NUM_EVT_REGS)) begin
        clr[{idx0, 3'b000} +: 8] = s_q.rdl[7:0]; // [RULE11] [RULE17]
      end
      if (s_q.be[1] && idx1 < 3'(NUM_EVT_REGS)) begin
        clr[{idx1, 3'b000} +: 8] = s_q.rdl[15:8]; // [RULE11] [RULE17]
      end
    end
  end

  always_comb begin
    rx_len = i_rx_queue_length;
    if (i_rx_queue_length < RX_LEN_MIN) begin
      rx_len = RX_LEN_MIN; // [RULE9]
    end else if (i_rx_queue_length > RX_LEN_RESET) begin
      rx_len = RX_LEN_RESET; // [RULE9]
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.sync1 = {i_ale, i_cs_n, i_rd_rw, i_wr_ds_n, i_upper_lane_select_n,
                 i_lower_lane_select_n, i_bus_style_select, i_bus_width_select,
                 i_addr, i_data};
    s_d.sync2 = s_q.sync1;
    s_d.ale_prev = s_ale;
    s_d.reg_rd = 1'b0;
    s_d.reg_wr = 1'b0;
    rx_pop = 1'b0;
    tx_push = 1'b0;
    tx_byte = cl ? s_q.wd[15:8] : s_q.wd[7:0];
    // A latch strobe that ever moves marks a multiplexed bus
    if (s_ale != s_q.ale_prev) begin
      s_d.muxed = 1'b1; // [RULE4]
    end
    if (s_q.ale_prev && !s_ale) begin
      s_d.ale_addr = s_data[7:0]; // [RULE4]
    end
    case (s_q.st)
      ST_IDLE: begin
        if (acc) begin
          s_d.addr = cur_addr;
          s_d.rd = is_read;
          s_d.be = be_c;
          s_d.wide = s_width;
          s_d.swap = style_ds;
          s_d.wd = {lane1_in, lane0_in};
          s_d.rdl = '0;
          s_d.reg_rd = (kind_c == KIND_EXT) && is_read && (be_c != 2'b00);
          s_d.reg_wr = (kind_c == KIND_EXT) && !is_read && (be_c != 2'b00);
          s_d.st = ST_FIRST;
        end
      end
      ST_FIRST, ST_SECOND: begin
        s_d.st = ST_HOLD;
        case (kind_q)
          KIND_FIFO: begin
            // Words are split into two byte moves, even byte first
            if (s_q.be != 2'b00) begin // [RULE6] [RULE7]
              if (s_q.rd) begin
                rx_pop = rx_valid_h;
                s_d.rdl[{cl, 3'b000} +: 8] = rx_valid_h ? rx_head : 8'h00;
              end else begin
                tx_push = tx_ready_h;
              end
            end
            if (s_q.st == ST_FIRST && s_q.be == 2'b11) begin
              s_d.st = ST_SECOND; // [RULE8]
            end
          end
          KIND_STAT: begin
            s_d.rdl = {stat_bytes[{idx1, 3'b000} +: 8], stat_bytes[{idx0, 3'b000} +: 8]};
          end
          KIND_MASK: begin
            if (s_q.rd) begin
              s_d.rdl = {s_q.mask[{idx1, 3'b000} +: 8], s_q.mask[{idx0, 3'b000} +: 8]};
            end else begin
              if (s_q.be[0]) begin
                s_d.mask[{idx0, 3'b000} +: 8] = s_q.wd[7:0];
              end
              if (s_q.be[1]) begin
                s_d.mask[{idx1, 3'b000} +: 8] = s_q.wd[15:8];
              end
            end
          end
          default: begin
            s_d.rdl = i_reg_rdata;
          end
        endcase
        if (s_q.be[0] == 1'b0) begin
          s_d.rdl[7:0] = 8'h00;
        end
        if (s_q.be[1] == 1'b0) begin
          s_d.rdl[15:8] = 8'h00;
        end
      end
      ST_HOLD: begin
        // 8-bit bus always answers on the low pins
        if (!s_q.wide) begin
          s_d.dout = {8'h00, s_q.addr[0] ? s_q.rdl[15:8] : s_q.rdl[7:0]}; // [RULE20]
        end else begin
          s_d.dout = s_q.swap ? {s_q.rdl[7:0], s_q.rdl[15:8]} : s_q.rdl; // [RULE5]
        end
        s_d.doe = s_q.rd && (s_q.be != 2'b00) && acc;
        if (!acc) begin
          s_d.st = ST_IDLE;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
    // Summary holds still while any status register is being read
    if (!freeze) begin
      s_d.summary = active; // [RULE13] [RULE15]
    end
    s_d.irq_n = !(|s_q.summary); // [RULE14]
    s_d.irq_oe = i_irq_output_config || (|s_q.summary); // [RULE10]
    s_d.blk_rdy = rx_count >= rx_len[5:0];
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      s_q <= '0;
      s_q.mask <= {NUM_EVT_REGS{MASK_RESET}};
      s_q.irq_n <= 1'b1;
      {s_q.sync1, s_q.sync2} <= {2{PIN_IDLE}}; // Idle pin levels, no false access
    end else begin
      s_q <= s_d;
    end
  end

  for (genvar g = 0; g < NUM_EVT_REGS; g++) begin : g_evt
    event_flag_reg u_flags (
      .i_ref_clk(i_ref_clk),
      .i_reset(i_reset),
      .i_events(i_events[g*EVT_W +: EVT_W]),
      .i_mask(s_q.mask[g*EVT_W +: EVT_W]),
      .i_show_masked(i_show_masked_events),
      .i_freeze(freeze),
      .i_clear(clr[g*EVT_W +: EVT_W]),
      .o_visible(visible[g*EVT_W +: EVT_W]),
      .o_active(active[g])
    );
  end

  byte_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_rx_queue (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_w_data(i_rx_data),
    .i_w_valid(i_rx_valid),
    .o_w_ready(o_rx_ready),
    .o_r_data(rx_head),
    .o_r_valid(rx_valid_h),
    .i_r_ready(rx_pop),
    .o_count(rx_count)
  );

  byte_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_tx_queue (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_w_data(tx_byte),
    .i_w_valid(tx_push),
    .o_w_ready(tx_ready_h),
    .o_r_data(o_tx_data),
    .o_r_valid(o_tx_valid),
    .i_r_ready(i_tx_ready),
    .o_count()
  );

  assign o_data = s_q.dout;
  assign o_data_oe = s_q.doe;
  assign o_irq_out_n = s_q.irq_n;
  assign o_irq_out_oe = s_q.irq_oe;
  assign o_reg_rd = s_q.reg_rd;
  assign o_reg_wr = s_q.reg_wr;
  assign o_reg_addr = {s_q.addr[7:1], 1'b0};
  assign o_reg_be = s_q.be;
  assign o_reg_wdata = s_q.wd;
  assign o_rx_block_ready = s_q.blk_rdy;

  sequence seq_word_split;
    s_q.st == ST_SECOND ##1 s_q.st == ST_HOLD;
  endsequence

  a_irq_assert: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [RULE10]
    (s_q.summary != '0) |=> (!o_irq_out_n && o_irq_out_oe)) else $error("irq not driven");
  a_irq_release: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [RULE14]
    (s_q.summary == '0 && !i_irq_output_config) |=> !o_irq_out_oe) else $error("irq held");
  a_no_lane: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [RULE2]
    (s_q.st == ST_FIRST && s_q.be == 2'b00) |-> (!rx_pop && !tx_push && !o_reg_rd && !o_reg_wr))
    else $error("transfer with no lane");
  a_narrow_byte: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [RULE8]
    (s_q.st == ST_FIRST && !s_q.wide) |=> s_q.st != ST_SECOND) else $error("word on 8-bit");
  a_word_fifo: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [RULE6]
    (s_q.st == ST_FIRST && kind_q == KIND_FIFO && s_q.be == 2'b11) |=> seq_word_split)
    else $error("word queue access not split");
  a_sum_hold: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [RULE15]
    freeze |=> $stable(s_q.summary)) else $error("summary moved during read");
  a_sum_clear: assert property (@(posedge i_ref_clk) disable iff (i_reset) // [RULE13]
    (!freeze && active == '0) |=> s_q.summary == '0) else $error("summary stuck");
endmodule : host_bus_port
`default_nettype wire

//--- dv/host_cpu_model.sv
// Purpose: Processor-side model that drives the host port pins.
// Assumes: Straps stay steady across each access; one access at a time.
// Notes: Released data lines show the inverse of drv_q, the model's held data word.
`timescale 1ns/10ps
`default_nettype none
module host_cpu_model (
  input wire logic i_ref_clk,
  input wire logic i_style,
  input wire logic i_mux,
  input wire logic [15:0] i_dev_data,
  input wire logic i_dev_oe,
  output logic o_ale,
  output logic o_cs_n,
  output logic o_rd_rw,
  output logic o_wr_ds_n,
  output logic o_upper_n,
  output logic o_lower_n,
  output logic [7:0] o_addr,
  output logic [15:0] o_data
);
  logic drv_en = 1'b0;
  logic [15:0] drv_q = 16'h0000;

  // Wire level: port, then this model, else a floating line that is not the last value
  assign o_data = i_dev_oe ? i_dev_data : (drv_en ? drv_q : ~drv_q);

  initial begin
    o_ale = 1'b0;
    o_cs_n = 1'b1;
    o_rd_rw = 1'b1;
    o_wr_ds_n = 1'b1;
    o_upper_n = 1'b1;
    o_lower_n = 1'b1;
    o_addr = 8'h00;
  end

  task automatic access(input logic wr, input logic [7:0] a, input logic ln,
      input logic [15:0] wd, output logic [15:0] rd, output logic ok);
    rd = 16'h0000;
    ok = 1'b0;
    @(posedge i_ref_clk);
    o_cs_n <= 1'b0;
    o_addr <= i_mux ? ~a : a; // Wrong pins prove the latched address is used
    o_upper_n <= ln;
    o_lower_n <= ln;
    o_rd_rw <= i_style ? ~wr : 1'b1;
    drv_en <= wr | i_mux;
    drv_q <= i_mux ? {8'h00, a} : wd;
    o_ale <= i_mux;
    @(posedge i_ref_clk);
    o_ale <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    drv_en <= wr;
    drv_q <= wd;
    @(posedge i_ref_clk);
    if (i_style | wr) begin
      o_wr_ds_n <= 1'b0;
    end else begin
      o_rd_rw <= 1'b0;
    end
    if (wr) begin
      repeat (8) @(posedge i_ref_clk);
      ok = 1'b1;
    end else begin
      for (int i = 0; i < 12 && !ok; i++) begin
        @(posedge i_ref_clk);
        #1;
        if (i_dev_oe === 1'b1) begin
          ok = 1'b1;
          rd = i_dev_data;
        end
      end
    end
    @(posedge i_ref_clk);
    o_rd_rw <= 1'b1;
    o_wr_ds_n <= 1'b1;
    @(posedge i_ref_clk);
    o_cs_n <= 1'b1;
    drv_en <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
  endtask : access
endmodule : host_cpu_model
`default_nettype wire

//--- dv/host_bus_port_test.sv
// Purpose: Sequence tests of the host port through its own pin protocol.
// Assumes: Straps change only under reset; outside registers hold addr ^ a5.
// Notes: Lane placement is worked out here, never read back from the port.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
  $display("wrong value %s expected %h seen %h", nm, exp, got); fail_count++; end end
module host_bus_port_test;
  import host_port_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_bus_style_select = 1'b0;
  logic i_bus_width_select = 1'b1;
  logic i_irq_output_config = 1'b0;
  logic i_show_masked_events = 1'b0;
  logic i_rx_valid = 1'b0;
  logic i_tx_ready = 1'b0;
  logic mux_q = 1'b0;
  logic [ALL_EVT_W-1:0] i_events = '0;
  logic [FIFO_W-1:0] i_rx_data = 8'h00;
  logic [5:0] i_rx_queue_length = RX_LEN_RESET;
  logic ale, cs_n, rd_rw, wr_ds_n, up_n, lo_n;
  logic [ADDR_W-1:0] pin_addr, o_reg_addr, wr_addr;
  logic [DATA_W-1:0] pin_data, o_data, o_reg_wdata, i_reg_rdata, wr_data, rd;
  logic o_data_oe, o_irq_out_n, o_irq_out_oe, o_reg_rd, o_reg_wr, o_rx_ready;
  logic o_rx_block_ready, o_tx_valid, ok, acc;
  logic [1:0] o_reg_be, wr_be;
  logic [FIFO_W-1:0] o_tx_data;
  logic [7:0] tx_q[$];
  int fail_count = 0;
  int cmp_count = 0;

  always #25 i_ref_clk = ~i_ref_clk;

  function automatic logic [7:0] regv(input logic [7:0] a);
    return a ^ 8'ha5;
  endfunction : regv

  assign i_reg_rdata = o_reg_rd ? {regv(o_reg_addr + 8'h01), regv(o_reg_addr)} : '0;

  always @(posedge i_ref_clk) begin
    if (o_reg_wr === 1'b1) begin
      wr_addr <= o_reg_addr;
      wr_be <= o_reg_be;
      wr_data <= o_reg_wdata;
    end
  end

  // Byte counted at the negedge before the edge that moves it
  always @(negedge i_ref_clk) begin
    if (i_tx_ready && o_tx_valid === 1'b1) tx_q.push_back(o_tx_data);
  end

  host_cpu_model cpu (.i_ref_clk(i_ref_clk), .i_style(i_bus_style_select), .i_mux(mux_q),
    .i_dev_data(o_data), .i_dev_oe(o_data_oe), .o_ale(ale), .o_cs_n(cs_n), .o_rd_rw(rd_rw),
    .o_wr_ds_n(wr_ds_n), .o_upper_n(up_n), .o_lower_n(lo_n), .o_addr(pin_addr),
    .o_data(pin_data));

  host_bus_port dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .i_bus_style_select(i_bus_style_select), .i_bus_width_select(i_bus_width_select),
    .i_ale(ale), .i_cs_n(cs_n), .i_rd_rw(rd_rw), .i_wr_ds_n(wr_ds_n),
    .i_upper_lane_select_n(up_n), .i_lower_lane_select_n(lo_n), .i_addr(pin_addr),
    .i_data(pin_data), .o_data(o_data), .o_data_oe(o_data_oe), .o_irq_out_n(o_irq_out_n),
    .o_irq_out_oe(o_irq_out_oe), .i_irq_output_config(i_irq_output_config),
    .i_show_masked_events(i_show_masked_events), .i_events(i_events), .o_reg_rd(o_reg_rd),
    .o_reg_wr(o_reg_wr), .o_reg_addr(o_reg_addr), .o_reg_be(o_reg_be),
    .o_reg_wdata(o_reg_wdata), .i_reg_rdata(i_reg_rdata), .i_rx_data(i_rx_data),
    .i_rx_valid(i_rx_valid), .o_rx_ready(o_rx_ready), .i_rx_queue_length(i_rx_queue_length),
    .o_rx_block_ready(o_rx_block_ready), .o_tx_data(o_tx_data), .o_tx_valid(o_tx_valid),
    .i_tx_ready(i_tx_ready));

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  task automatic do_reset(input logic style, input logic width, input logic mux);
    @(posedge i_ref_clk);
    i_reset <= 1'b1;
    i_bus_style_select <= style;
    i_bus_width_select <= width;
    mux_q <= mux;
    repeat (10) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
  endtask : do_reset

  task automatic wait3;
    repeat (3) @(posedge i_ref_clk);
    #1;
  endtask : wait3

  task automatic rd_chk(input logic [7:0] a, input logic ln, input logic [15:0] exp);
    cpu.access(1'b0, a, ln, 16'h0000, rd, ok);
    `CHK("read answered", 1'b1, ok)
    `CHK("read data", exp, rd)
  endtask : rd_chk

  task automatic nop_chk(input logic [7:0] a);
    cpu.access(1'b0, a, 1'b1, 16'h0000, rd, ok);
    `CHK("no transfer", 1'b0, ok)
  endtask : nop_chk

  task automatic wr(input logic [7:0] a, input logic ln, input logic [15:0] d);
    cpu.access(1'b1, a, ln, d, rd, ok);
  endtask : wr

  task automatic ev(input int idx);
    @(posedge i_ref_clk);
    i_events <= 48'h1 << idx;
    @(posedge i_ref_clk);
    i_events <= '0;
  endtask : ev

  task automatic push_rx(input logic [7:0] b, output logic accepted);
    accepted = 1'b0;
    @(posedge i_ref_clk);
    i_rx_valid <= 1'b1;
    i_rx_data <= b;
    for (int i = 0; i < 4 && !accepted; i++) begin
      @(negedge i_ref_clk);
      accepted = (o_rx_ready === 1'b1);
    end
    @(posedge i_ref_clk);
    i_rx_valid <= 1'b0;
  endtask : push_rx

  initial begin
    do_reset(1'b0, 1'b1, 1'b0);
    #1;
    `CHK("oe after reset", 1'b0, o_data_oe)
    ev(0);
    wait3();
    `CHK("irq masked at reset", 1'b1, o_irq_out_n)
    rd_chk(8'h10, 1'b0, {regv(8'h11), regv(8'h10)});
    rd_chk(8'h11, 1'b0, {regv(8'h11), 8'h00});
    rd_chk(8'h10, 1'b1, {8'h00, regv(8'h10)});
    nop_chk(8'h11);
    wr(8'h20, 1'b0, 16'hbeef);
    `CHK("word write", {8'h20, 2'b11, 16'hbeef}, {wr_addr, wr_be, wr_data})
    wr(8'h00, 1'b0, 16'h2211);
    wr(8'h00, 1'b1, 16'h0033);
    wait3();
    `CHK("tx held while stalled", 1'b1, o_tx_valid)
    @(posedge i_ref_clk);
    i_tx_ready <= 1'b1;
    for (int i = 0; i < 20 && tx_q.size() < 3; i++) @(posedge i_ref_clk);
    `CHK("tx count", 3, tx_q.size())
    `CHK("tx bytes", 24'h112233, {tx_q[0], tx_q[1], tx_q[2]})
    @(posedge i_ref_clk);
    i_rx_queue_length <= 6'h01;
    for (int i = 0; i < 33; i++) begin
      push_rx(8'(i + 64), acc);
      if (i < 2) begin
        wait3();
        `CHK("block ready", i == 1, o_rx_block_ready)
      end
      `CHK("rx accepted", i < 32, acc)
    end
    @(posedge i_ref_clk);
    i_rx_queue_length <= 6'h20;
    wait3();
    `CHK("block ready full", 1'b1, o_rx_block_ready)
    rd_chk(8'h00, 1'b0, 16'h4140);
    rd_chk(8'h00, 1'b1, 16'h0042);
    for (int k = 0; k < 14; k++) rd_chk(8'h00, 1'b0, {8'(68 + 2 * k), 8'(67 + 2 * k)});
    rd_chk(8'h00, 1'b1, 16'h005f);
    rd_chk(8'h00, 1'b1, 16'h0000);
    wr(8'h60, 1'b1, 16'h00fe);
    wr(8'h63, 1'b0, 16'hfb00);
    ev(0);
    ev(1);
    ev(26);
    wait3();
    `CHK("irq level", 2'b01, {o_irq_out_n, o_irq_out_oe})
    rd_chk(8'h6e, 1'b1, 16'h0009);
    rd_chk(8'h6b, 1'b0, 16'h0400);
    fork
      rd_chk(8'h68, 1'b1, 16'h0001);
      begin
        repeat (9) @(posedge i_ref_clk);
        ev(0);
      end
    join
    wait3();
    `CHK("irq kept by parked event", 1'b0, o_irq_out_n)
    rd_chk(8'h68, 1'b1, 16'h0001);
    wait3();
    `CHK("irq released", 2'b10, {o_irq_out_n, o_irq_out_oe})
    rd_chk(8'h6e, 1'b1, 16'h0000);
    @(posedge i_ref_clk);
    i_show_masked_events <= 1'b1;
    ev(1);
    wait3();
    `CHK("masked visible no irq", 1'b1, o_irq_out_n)
    rd_chk(8'h6e, 1'b1, 16'h0000);
    rd_chk(8'h68, 1'b1, 16'h0002);
    ev(1);
    ev(0);
    wait3();
    rd_chk(8'h68, 1'b1, 16'h0003);
    rd_chk(8'h68, 1'b1, 16'h0000);
    @(posedge i_ref_clk);
    i_irq_output_config <= 1'b1;
    wait3();
    `CHK("push-pull idle", 2'b11, {o_irq_out_n, o_irq_out_oe})
    do_reset(1'b1, 1'b1, 1'b0);
    rd_chk(8'h10, 1'b0, {regv(8'h10), regv(8'h11)});
    rd_chk(8'h11, 1'b0, {8'h00, regv(8'h11)});
    rd_chk(8'h10, 1'b1, {regv(8'h10), 8'h00});
    nop_chk(8'h11);
    wr(8'h20, 1'b0, 16'hbeef);
    `CHK("word write swapped", 16'hefbe, wr_data)
    do_reset(1'b0, 1'b0, 1'b0);
    rd_chk(8'h11, 1'b0, {8'h00, regv(8'h11)});
    rd_chk(8'h10, 1'b0, {8'h00, regv(8'h10)});
    push_rx(8'h71, acc);
    push_rx(8'h72, acc);
    rd_chk(8'h00, 1'b0, 16'h0071);
    rd_chk(8'h00, 1'b0, 16'h0072);
    do_reset(1'b0, 1'b1, 1'b1);
    rd_chk(8'h30, 1'b0, {regv(8'h31), regv(8'h30)});
    wr(8'h41, 1'b0, 16'h7700);
    `CHK("multiplexed write", {8'h40, 2'b10, 8'h77}, {wr_addr, wr_be, wr_data[15:8]})
    conclude();
  end
endmodule : host_bus_port_test
`default_nettype wire
